// *** swsr_regs.sv ***
// Implementation choices: the strobed register port and the placing of the registers.
module swsr_regs #(
   parameter bit CHALLENGER_VARIANT = 1'b1
) (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic [swsr_pkg::ADDR_W-1:0] addr,
   input  wire logic [swsr_pkg::DATA_W-1:0] wr_data,
   input  wire logic                        wr_stb,
   input  wire logic                        rd_stb,
   output logic      [swsr_pkg::DATA_W-1:0] rd_data,
   input  wire logic                        analog_selftest_done,
   input  wire logic [14:0]                 analog_selftest_faults,
   input  wire logic                        pin_check_done,
   input  wire logic [5:0]                  pin_stuck_faults,
   input  wire logic                        logic_selftest_done,
   input  wire logic                        logic_selftest_pass,
   output logic      [3:0]                  window_duration,
   output logic      [2:0]                  window_duty,
   output logic                             refresh_good,
   output logic                             refresh_bad,
   output logic                             analog_selftest_start,
   output logic                             ondemand_selftest_req
);
   import swsr_pkg::*;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [DATA_W-1:0] window_config;
   logic [DATA_W-1:0] inverted_window_config;
   logic [DATA_W-1:0] refresh_seed_value;
   logic [DATA_W-1:0] refresh_response_value;
   logic              last_good;
   logic              last_bad;
   logic              seed_refused;

   swsr_st_if st_bus ();

   swsr_selftest u_selftest (
      .clk            (clk),
      .reset          (reset),
      .bus            (st_bus.st),
      .analog_done    (analog_selftest_done),
      .analog_faults  (analog_selftest_faults),
      .pin_check_done (pin_check_done),
      .pin_faults     (pin_stuck_faults),
      .logic_done     (logic_selftest_done),
      .logic_pass     (logic_selftest_pass)
   );

   // ****************************************************************
   // Address decode
   // ****************************************************************
   wire logic wr_window     = wr_stb && (addr == OFS_WINDOW_CONFIG);
   wire logic wr_inv_window = wr_stb && (addr == OFS_INV_WINDOW_CONFIG);
   wire logic wr_seed       = wr_stb && (addr == OFS_SEED);
   wire logic wr_response   = wr_stb && (addr == OFS_RESPONSE);
   wire logic wr_status     = wr_stb && (addr == OFS_REFRESH_STATUS);

   assign st_bus.wr_req = wr_stb && (addr == OFS_SELFTEST_REQ);
   assign st_bus.wr_inv = wr_stb && (addr == OFS_INV_SELFTEST_REQ);
   assign st_bus.wbit   = wr_data[0];

   // ****************************************************************
   // Window configuration pair
   // ****************************************************************
   // Only the defined fields are stored; other bits read as zero
   wire logic [DATA_W-1:0] win_field_mask = MASK_DURATION | MASK_DUTY;

   // Compare on the stored pair, so a half-written pair never applies
   wire logic duration_ok = swsr_inverse_ok(window_config, inverted_window_config,
                                            MASK_DURATION);
   wire logic duty_ok     = swsr_inverse_ok(window_config, inverted_window_config,
                                            MASK_DUTY);

   wire logic [3:0] next_duration = duration_ok ?
                    window_config[POS_DURATION +: 4] : window_duration;
   wire logic [2:0] next_duty     = duty_ok ?
                    window_config[POS_DUTY +: 3] : window_duty;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         window_config          <= RST_WINDOW_CONFIG;
         inverted_window_config <= RST_INV_WINDOW_CONFIG;
      end else begin
         if (wr_window) begin
            window_config <= wr_data & win_field_mask;
         end
         if (wr_inv_window) begin
            // Every code of both inverted fields is accepted
            inverted_window_config <= wr_data & win_field_mask;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         window_duration <= RST_WINDOW_CONFIG[POS_DURATION +: 4];
         window_duty     <= RST_WINDOW_CONFIG[POS_DUTY +: 3];
      end else begin
         window_duration <= next_duration;
         window_duty     <= next_duty;
      end
   end

   // ****************************************************************
   // Seed guard
   // ****************************************************************
   wire logic seed_is_ones  = (wr_data == SEED_ALL_ONES);
   wire logic seed_is_zeros = (wr_data == SEED_ALL_ZEROS);
   wire logic seed_forbid   = CHALLENGER_VARIANT ? seed_is_ones
                                                 : (seed_is_ones || seed_is_zeros);
   wire logic seed_accept   = wr_seed && !seed_forbid;
   wire logic seed_reject   = wr_seed && seed_forbid;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refresh_seed_value <= RST_SEED;
      end else if (seed_accept) begin
         refresh_seed_value <= wr_data;
      end
   end

   // ****************************************************************
   // Refresh response judgement
   // ****************************************************************
   // Judged against the seed held at the moment of the write
   wire logic [DATA_W-1:0] expected_response =
      CHALLENGER_VARIANT ? ~refresh_seed_value
                         : refresh_seed_value;
   wire logic response_match = (wr_data == expected_response);
   wire logic good_now       = wr_response && response_match;
   wire logic bad_now        = wr_response && !response_match;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refresh_response_value <= RST_ZERO;
         refresh_good           <= 1'b0;
         refresh_bad            <= 1'b0;
      end else begin
         refresh_good <= good_now;
         refresh_bad  <= bad_now;
         if (wr_response) begin
            refresh_response_value <= wr_data;
         end
      end
   end

   // ****************************************************************
   // Refresh status
   // ****************************************************************
   // Refusal is sticky so a polled write can still be checked;
   // a new refusal wins over a write-one clear in the same cycle
   wire logic clr_refused  = wr_status && wr_data[POS_ST_REFUSED];
   wire logic next_refused = seed_reject ? 1'b1 : (clr_refused ? 1'b0 : seed_refused);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         last_good    <= 1'b0;
         last_bad     <= 1'b0;
         seed_refused <= 1'b0;
      end else begin
         seed_refused <= next_refused;
         if (wr_response) begin
            last_good <= response_match;
            last_bad  <= !response_match;
         end
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   logic [DATA_W-1:0] read_mux;
   logic [DATA_W-1:0] status_word;

   always_comb begin
      status_word                 = RST_ZERO;
      status_word[POS_ST_GOOD]    = last_good;
      status_word[POS_ST_BAD]     = last_bad;
      status_word[POS_ST_REFUSED] = seed_refused;
   end

   // Results are only ever read; writes to them are dropped
   always_comb begin
      unique case (addr)
         OFS_WINDOW_CONFIG:     read_mux = window_config;
         OFS_INV_WINDOW_CONFIG: read_mux = inverted_window_config;
         OFS_SEED:              read_mux = refresh_seed_value;
         OFS_RESPONSE:          read_mux = refresh_response_value;
         OFS_SELFTEST_REQ:      read_mux = {15'h0000, st_bus.req_bit};
         OFS_INV_SELFTEST_REQ:  read_mux = {15'h0000, st_bus.inv_bit};
         OFS_ANALOG_RESULTS:    read_mux = {1'b0, st_bus.analog_res} & MASK_ANALOG;
         OFS_PIN_LOGIC_RESULTS: read_mux = st_bus.pin_logic_res;
         OFS_REFRESH_STATUS:    read_mux = status_word;
         default:               read_mux = RST_ZERO;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_data <= RST_ZERO;
      end else if (rd_stb) begin
         rd_data <= read_mux;
      end else begin
         rd_data <= RST_ZERO;
      end
   end

   // ****************************************************************
   // Self-test outputs
   // ****************************************************************
   assign analog_selftest_start = st_bus.start;
   assign ondemand_selftest_req = st_bus.req_bit;

endmodule // swsr_regs

// *** swsr_pkg.sv ***
package swsr_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;

   // ****************************************************************
   // Register indices
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_WINDOW_CONFIG     = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_INV_WINDOW_CONFIG = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_SEED              = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_RESPONSE          = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_SELFTEST_REQ      = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_INV_SELFTEST_REQ  = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_ANALOG_RESULTS    = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_PIN_LOGIC_RESULTS = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_REFRESH_STATUS    = 4'h8;

   // ****************************************************************
   // Field layout
   // ****************************************************************
   localparam logic [DATA_W-1:0] MASK_DURATION   = 16'hF000;
   localparam logic [DATA_W-1:0] MASK_DUTY       = 16'h0700;
   localparam logic [DATA_W-1:0] MASK_REQ        = 16'h0001;
   localparam logic [DATA_W-1:0] MASK_ANALOG     = 16'h7FFF;
   localparam int unsigned       POS_DURATION    = 12;
   localparam int unsigned       POS_DUTY        = 8;
   localparam int unsigned       POS_PIN_FAULTS  = 8;
   localparam int unsigned       POS_LOGIC_RAN   = 1;
   localparam int unsigned       POS_LOGIC_PASS  = 0;
   localparam int unsigned       POS_ST_GOOD     = 0;
   localparam int unsigned       POS_ST_BAD      = 1;
   localparam int unsigned       POS_ST_REFUSED  = 2;

   // ****************************************************************
   // Reset values and forbidden seeds
   // ****************************************************************
   localparam logic [DATA_W-1:0] RST_WINDOW_CONFIG     = 16'h0000;
   localparam logic [DATA_W-1:0] RST_INV_WINDOW_CONFIG = 16'hF700;
   localparam logic [DATA_W-1:0] RST_SEED              = 16'h5AB2;
   localparam logic [DATA_W-1:0] RST_ZERO              = 16'h0000;
   localparam logic [DATA_W-1:0] SEED_ALL_ONES         = 16'hFFFF;
   localparam logic [DATA_W-1:0] SEED_ALL_ZEROS        = 16'h0000;

   // True when every masked bit of a is the inverse of b
   function automatic logic swsr_inverse_ok(input logic [DATA_W-1:0] a,
                                            input logic [DATA_W-1:0] b,
                                            input logic [DATA_W-1:0] mask);
      swsr_inverse_ok = (((a ^ b) & mask) == mask);
   endfunction

endpackage

// *** swsr_st_if.sv ***
interface swsr_st_if;
   import swsr_pkg::*;
   logic              wr_req;
   logic              wr_inv;
   logic              wbit;
   logic              req_bit;
   logic              inv_bit;
   logic              start;
   logic [14:0]       analog_res;
   logic [DATA_W-1:0] pin_logic_res;

   modport regs (output wr_req, output wr_inv, output wbit,
                 input req_bit, input inv_bit, input start,
                 input analog_res, input pin_logic_res);
   modport st   (input wr_req, input wr_inv, input wbit,
                 output req_bit, output inv_bit, output start,
                 output analog_res, output pin_logic_res);
endinterface

// *** swsr_selftest.sv ***
module swsr_selftest (
   input  wire logic        clk,
   input  wire logic        reset,
   swsr_st_if.st            bus,
   input  wire logic        analog_done,
   input  wire logic [14:0] analog_faults,
   input  wire logic        pin_check_done,
   input  wire logic [5:0]  pin_faults,
   input  wire logic        logic_done,
   input  wire logic        logic_pass
);
   import swsr_pkg::*;

   logic        req_bit;
   logic        inv_bit;
   logic        start;
   logic [14:0] analog_res;
   logic [5:0]  pin_res;
   logic        logic_ran;
   logic        logic_passed;

   wire logic   req_ok     = bus.wr_req && bus.wbit && (bus.wbit == ~inv_bit);
   wire logic   next_req   = req_ok ? 1'b1 : (analog_done ? 1'b0 : req_bit);

   // ****************************************************************
   // Request, complement and start
   // ****************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         req_bit <= 1'b0;
         inv_bit <= 1'b1;
         start   <= 1'b0;
      end else begin
         req_bit <= next_req;
         start   <= req_ok;
         if (bus.wr_inv) begin
            inv_bit <= bus.wbit;
         end
      end
   end

   // ****************************************************************
   // Sticky results, cleared only by reset; the logic pass bit is rewritten by each logic run
   // ****************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         analog_res   <= 15'h0000;
         pin_res      <= 6'h00;
         logic_ran    <= 1'b0;
         logic_passed <= 1'b0;
      end else begin
         if (analog_done) begin
            analog_res <= analog_res | analog_faults;
         end
         if (pin_check_done) begin
            pin_res <= pin_res | pin_faults;
         end
         if (logic_done) begin
            logic_ran    <= 1'b1;
            logic_passed <= logic_pass;
         end
      end
   end

   assign bus.req_bit       = req_bit;
   assign bus.inv_bit       = inv_bit;
   assign bus.start         = start;
   assign bus.analog_res    = analog_res;
   assign bus.pin_logic_res = {2'b00, pin_res, 6'h00, logic_ran, logic_passed};
endmodule // swsr_selftest

// *** swsr_regs_properties.sv ***
module swsr_regs_checker
   import swsr_pkg::*;
#(
   parameter bit CHALLENGER_VARIANT = 1'b1
) (
   input wire logic                        clk,
   input wire logic                        reset,
   input wire logic [swsr_pkg::ADDR_W-1:0] addr,
   input wire logic [swsr_pkg::DATA_W-1:0] wr_data,
   input wire logic                        wr_stb,
   input wire logic                        rd_stb,
   input wire logic [swsr_pkg::DATA_W-1:0] rd_data,
   input wire logic                        analog_selftest_done,
   input wire logic [3:0]                  window_duration,
   input wire logic [2:0]                  window_duty,
   input wire logic                        refresh_good,
   input wire logic                        refresh_bad,
   input wire logic                        analog_selftest_start,
   input wire logic                        ondemand_selftest_req
);
   // ****************************************************************
   // Helper logic
   // ****************************************************************
   logic resp_wr_q;
   logic req_wr_q;
   logic seed_rd_q;
   logic win_wr_q1;
   logic win_wr_q2;
   wire logic resp_wr = wr_stb && addr == OFS_RESPONSE;
   wire logic req_wr  = wr_stb && addr == OFS_SELFTEST_REQ && wr_data[0];
   wire logic seed_rd = rd_stb && addr == OFS_SEED;
   wire logic win_wr  = wr_stb && (addr == OFS_WINDOW_CONFIG || addr == OFS_INV_WINDOW_CONFIG);

   // Window outputs lag the write by two samples
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {resp_wr_q, req_wr_q, seed_rd_q, win_wr_q1, win_wr_q2} <= 5'h00;
      end else begin
         {resp_wr_q, req_wr_q, seed_rd_q, win_wr_q1, win_wr_q2} <=
            {resp_wr, req_wr, seed_rd, win_wr, win_wr_q1};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_seed_legal;
      seed_rd_q |-> rd_data != SEED_ALL_ONES && (CHALLENGER_VARIANT || rd_data != SEED_ALL_ZEROS);
   endproperty
   a_seed_legal: assert property (p_seed_legal) else $error("forbidden seed read back");
   property p_resp_judged;
      resp_wr_q |-> refresh_good != refresh_bad;
   endproperty
   a_resp_judged: assert property (p_resp_judged) else $error("response not judged once");
   property p_resp_cause;
      refresh_good || refresh_bad |-> resp_wr_q;
   endproperty
   a_resp_cause: assert property (p_resp_cause) else $error("refresh pulse without write");
   property p_start_cause;
      analog_selftest_start |-> req_wr_q && ondemand_selftest_req;
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("self-test start uncaused");
   property p_req_zero;
      wr_stb && addr == OFS_SELFTEST_REQ && !wr_data[0] && !ondemand_selftest_req
         |=> !ondemand_selftest_req && !analog_selftest_start;
   endproperty
   a_req_zero: assert property (p_req_zero) else $error("zero request acted");
   property p_req_hold;
      ondemand_selftest_req && !analog_selftest_done |=> ondemand_selftest_req;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   property p_req_clear;
      ondemand_selftest_req && analog_selftest_done && !wr_stb |=> !ondemand_selftest_req;
   endproperty
   a_req_clear: assert property (p_req_clear) else $error("request not cleared");
   property p_win_cause;
      $changed(window_duration) || $changed(window_duty) |-> win_wr_q2;
   endproperty
   a_win_cause: assert property (p_win_cause) else $error("window changed unasked");
endmodule // swsr_regs_checker

bind swsr_regs swsr_regs_checker #(.CHALLENGER_VARIANT(CHALLENGER_VARIANT)) swsr_regs_checker_i (
   .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rd_data(rd_data), .analog_selftest_done(analog_selftest_done),
   .window_duration(window_duration), .window_duty(window_duty),
   .refresh_good(refresh_good), .refresh_bad(refresh_bad),
   .analog_selftest_start(analog_selftest_start), .ondemand_selftest_req(ondemand_selftest_req));

// *** test_swsr_regs.sv ***
module test_swsr_regs;
   timeunit 1ns;
   timeprecision 1ns;
   import swsr_pkg::*;
   logic        clk, reset, wr_stb, rd_stb, a_done, p_done, l_done, l_pass;
   logic        good_c, bad_c, good_s, bad_s, start, req;
   logic [3:0]  addr, dur;
   logic [2:0]  duty;
   logic [14:0] a_faults;
   logic [5:0]  p_faults;
   logic [15:0] wr_data, rd_c, rd_s;
   int          n_errors, n_checks, cycles;

   swsr_regs #(.CHALLENGER_VARIANT(1'b1)) swsr_regs_i (.clk(clk), .reset(reset), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_c),
      .analog_selftest_done(a_done), .analog_selftest_faults(a_faults), .pin_check_done(p_done),
      .pin_stuck_faults(p_faults), .logic_selftest_done(l_done), .logic_selftest_pass(l_pass),
      .window_duration(dur), .window_duty(duty), .refresh_good(good_c), .refresh_bad(bad_c),
      .analog_selftest_start(start), .ondemand_selftest_req(req));
   // Simple variant shares the bus, its register reset values and its seed and refresh side are judged
   swsr_regs #(.CHALLENGER_VARIANT(1'b0)) swsr_regs_i2 (.clk(clk), .reset(reset), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_s),
      .analog_selftest_done(a_done), .analog_selftest_faults(a_faults), .pin_check_done(p_done),
      .pin_stuck_faults(p_faults), .logic_selftest_done(l_done), .logic_selftest_pass(l_pass),
      .window_duration(), .window_duty(), .refresh_good(good_s), .refresh_bad(bad_s),
      .analog_selftest_start(), .ondemand_selftest_req());

   // ****************************************************************
   // Bus and compare tasks
   // ****************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a; wr_data <= d; wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a; rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
   endtask
   // One-cycle completion pulse from a self-test engine
   task automatic fire(input logic [2:0] which, input logic [14:0] f);
      @(posedge clk);
      a_faults <= f; p_faults <= f[5:0]; l_pass <= f[0]; {l_done, p_done, a_done} <= which;
      @(posedge clk);
      {l_done, p_done, a_done} <= 3'b000;
      #1;
   endtask
   task automatic results;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset_values;
      logic [15:0] exp [10] = '{16'h0000, 16'hF700, 16'h5AB2, 16'h0000, 16'h0000,
                                16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      for (int i = 0; i < 10; i++) begin
         rd(4'(i));
         chk(rd_c, exp[i]);
         chk(rd_s, exp[i]);
      end
      chk({9'h000, dur, duty}, 16'h0000);
   endtask
   task automatic t_window;
      for (int i = 0; i < 16; i++) begin
         wr(OFS_INV_WINDOW_CONFIG, {~4'(i), 1'b0, ~3'(i), 8'h00});
         wr(OFS_WINDOW_CONFIG, {4'(i), 1'b0, 3'(i), 8'h00});
         @(posedge clk);
         #1;
         chk({12'h000, dur}, 16'(i));
         chk({13'h0000, duty}, 16'(i % 8));
      end
      wr(OFS_WINDOW_CONFIG, 16'h3200);
      repeat (2) @(posedge clk);
      #1;
      chk({9'h000, dur, duty}, 16'h007F);
      rd(OFS_INV_WINDOW_CONFIG);
      chk(rd_c, 16'h0000);
      wr(OFS_INV_WINDOW_CONFIG, 16'hC500);
      repeat (2) @(posedge clk);
      #1;
      chk({9'h000, dur, duty}, 16'h001A);
   endtask
   task automatic t_seed_refresh;
      wr(OFS_SEED, 16'h1234);
      wr(OFS_SEED, 16'hFFFF);
      rd(OFS_SEED);
      chk(rd_c, 16'h1234);
      chk(rd_s, 16'h1234);
      wr(OFS_SEED, 16'h0000);
      rd(OFS_SEED);
      chk(rd_c, 16'h0000);
      chk(rd_s, 16'h1234);
      wr(OFS_RESPONSE, 16'hFFFF);
      chk({12'h000, good_c, bad_c, good_s, bad_s}, 16'h0009);
      wr(OFS_RESPONSE, 16'h1234);
      chk({12'h000, good_c, bad_c, good_s, bad_s}, 16'h0006);
      wr(OFS_RESPONSE, 16'h1235);
      chk({12'h000, good_c, bad_c, good_s, bad_s}, 16'h0005);
      @(posedge clk);
      #1;
      chk({12'h000, good_c, bad_c, good_s, bad_s}, 16'h0000);
      rd(OFS_RESPONSE);
      chk(rd_c, 16'h1235);
      // Last judgement bad, refusal sticky until written off
      rd(OFS_REFRESH_STATUS);
      chk(rd_c, 16'h0006);
      chk(rd_s, 16'h0006);
      wr(OFS_REFRESH_STATUS, 16'h0004);
      rd(OFS_REFRESH_STATUS);
      chk(rd_c, 16'h0002);
      chk(rd_s, 16'h0002);
   endtask
   task automatic t_selftest;
      wr(OFS_SELFTEST_REQ, 16'h0001);
      chk({14'h0000, start, req}, 16'h0000);
      wr(OFS_INV_SELFTEST_REQ, 16'h0000);
      wr(OFS_SELFTEST_REQ, 16'h0000);
      chk({14'h0000, start, req}, 16'h0000);
      wr(OFS_SELFTEST_REQ, 16'h0001);
      chk({14'h0000, start, req}, 16'h0003);
      repeat (3) @(posedge clk);
      #1;
      chk({15'h0000, req}, 16'h0001);
      fire(3'b001, 15'h5A5C);
      chk({15'h0000, req}, 16'h0000);
      rd(OFS_ANALOG_RESULTS);
      chk(rd_c, 16'h5A5C);
      wr(OFS_SELFTEST_REQ, 16'h0001);
      fire(3'b001, 15'h25A3);
      wr(OFS_ANALOG_RESULTS, 16'h0000);
      rd(OFS_ANALOG_RESULTS);
      chk(rd_c, 16'h7FFF);
      fire(3'b010, 15'h002D);
      rd(OFS_PIN_LOGIC_RESULTS);
      chk(rd_c, 16'h2D00);
      fire(3'b100, 15'h0000);
      wr(OFS_PIN_LOGIC_RESULTS, 16'h0000);
      rd(OFS_PIN_LOGIC_RESULTS);
      chk(rd_c, 16'h2D02);
   endtask
   task automatic t_reset_again;
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(OFS_PIN_LOGIC_RESULTS);
      chk(rd_c, 16'h0000);
      rd(OFS_ANALOG_RESULTS);
      chk(rd_c, 16'h0000);
      fire(3'b100, 15'h0001);
      rd(OFS_PIN_LOGIC_RESULTS);
      chk(rd_c, 16'h0003);
   endtask

   // ****************************************************************
   // Clock, watchdog on the run, main sequence
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         $display("mismatch at %0t: run hung", $time);
         results();
      end
   end
   initial begin
      reset = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; addr = 4'h0; wr_data = 16'h0000;
      a_done = 1'b0; p_done = 1'b0; l_done = 1'b0; l_pass = 1'b0;
      a_faults = 15'h0000; p_faults = 6'h00;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_reset_values();
      t_window();
      t_seed_refresh();
      t_selftest();
      t_reset_again();
      results();
   end
endmodule // test_swsr_regs
